// File: design/fsh_home_search.sv
// direct feedback decode, scaling settings and drive-led home search
//
// Contract
// - type bit picks pulses-per-turn or signal period
// - coded bit enables distance-coded mark handling
// - direction bit inverts direct feedback count
// - structure bit flips coded mark count sense
// - motor/screw gear settings clamp to 32767
// - feedback/load gear settings clamp to 32767
// - travel-per-rev nonzero flags differing turn travel; the code raises the flag only with the type bit on rotary
// - coded marks judged by two spacing settings
// - feedback-select bit picks homed feedback, offsets
// - polarity bit picks normally open or closed
// - direction bit gives clockwise or counterclockwise
// - switch-use bit 1 skips the home switch
// - fast then slow speed, ramped by acceleration
// - software shift past switch before mark search
// - per-feedback offsets; no move after homing
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module fsh_home_search (
  input  wire logic                        clk_sys,
  input  wire logic                        resetn,
  input  wire fsh_pkg::fsh_bus_t           bus,
  output logic        [fsh_pkg::DATA_W-1:0] rdata,
  input  wire fsh_pkg::fsh_enc_t           motorEnc,
  input  wire fsh_pkg::fsh_enc_t           directEnc,
  input  wire logic                        homeSwitch,
  output logic signed [31:0]               speedCmd,
  output logic                             homeBusy,
  output logic                             homeDone
);
  import fsh_pkg::*;

  typedef struct packed {
    fsh_cfg_t          cfg;
    fsh_state_t        state;
    logic [1:0]        motorAb;
    logic [1:0]        directAb;
    logic              motorMark;
    logic              directMark;
    logic signed [31:0] motorPos;
    logic signed [31:0] directPos;
    logic signed [31:0] speed;
    logic signed [31:0] shiftLeft;
    logic signed [31:0] firstMark;
    logic              haveFirst;
    logic signed [31:0] markGap;
    logic              done;
    logic [DATA_W-1:0] rdata;
  } fsh_st_t;

  fsh_st_t st_q;
  fsh_st_t st_d;

  function automatic logic [15:0] satGear(input logic [31:0] w);
    satGear = (w > {16'h0000, GEAR_MAX}) ? GEAR_MAX : w[15:0];
  endfunction : satGear

  function automatic logic signed [31:0] quadStep(input logic [1:0] p,
                                                  input logic [1:0] c);
    logic [3:0] t;
    t = {p, c};
    case (t)
      4'h1, 4'h7, 4'hE, 4'h8: quadStep = 32'sd1;
      4'h2, 4'hB, 4'hD, 4'h4: quadStep = -32'sd1;
      default:                quadStep = 32'sd0;
    endcase
  endfunction : quadStep

  function automatic logic signed [31:0] absVal(input logic signed [31:0] v);
    absVal = (v < 0) ? -v : v;
  endfunction : absVal

  function automatic logic riseEdge(input logic now,
                                    input logic was);
    riseEdge = now & ~was;
  endfunction : riseEdge

  function automatic logic [31:0] zext16(input logic [15:0] v);
    zext16 = {16'h0000, v};
  endfunction : zext16

  logic signed [31:0] mStep;
  logic signed [31:0] dStep;
  logic               mMarkEdge;
  logic               dMarkEdge;
  logic               switchActive;
  logic               useDirect;
  logic               markSeen;
  logic signed [31:0] homePos;
  logic signed [31:0] target;
  logic signed [31:0] accelS;
  logic signed [31:0] gap;
  logic signed [31:0] codedGap;
  logic               coded;
  logic [5:0]         widx;
  logic               travelDiffers;

  always_comb
  begin
    st_d = st_q;
    widx = bus.addr[7:2];
    // quadrature steps
    mStep = quadStep(st_q.motorAb, {motorEnc.a, motorEnc.b});
    dStep = quadStep(st_q.directAb, {directEnc.a, directEnc.b});
    if (st_q.cfg.dfbSetup[DFB_INVERT])
    begin
      dStep = -dStep;
    end
    // reference mark edges
    mMarkEdge = riseEdge(motorEnc.mark, st_q.motorMark);
    dMarkEdge = riseEdge(directEnc.mark, st_q.directMark);
    travelDiffers = ~st_q.cfg.dfbSetup[DFB_LINEAR]
                    & (st_q.cfg.travel != 32'h0000_0000);
    switchActive = st_q.cfg.homeSetup[HS_NC] ? ~homeSwitch : homeSwitch;
    useDirect = st_q.cfg.homeSetup[HS_DIRECT];
    markSeen = useDirect ? dMarkEdge : mMarkEdge;
    coded = useDirect & st_q.cfg.dfbSetup[DFB_CODED];
    homePos = useDirect ? st_q.cfg.hvDirect + st_q.cfg.moDirect
                        : st_q.cfg.hvMotor + st_q.cfg.moMotor;
    gap = st_q.directPos - st_q.firstMark;
    codedGap = st_q.cfg.dfbSetup[DFB_STRUCT] ? -gap : gap;
    accelS = st_q.cfg.accel;
    target = 32'sd0;

    st_d.motorAb = {motorEnc.a, motorEnc.b};
    st_d.directAb = {directEnc.a, directEnc.b};
    st_d.motorMark = motorEnc.mark;
    st_d.directMark = directEnc.mark;
    st_d.motorPos = st_q.motorPos + mStep;
    st_d.directPos = st_q.directPos + dStep;

    // home search sequence
    case (st_q.state)
      HS_IDLE:
      begin
        target = 32'sd0;
      end
      HS_FAST:
      begin
        target = st_q.cfg.fastSpd;
        if (st_q.cfg.homeSetup[HS_NOSW])
        begin
          st_d.state = HS_SLOW;
        end
        else if (switchActive)
        begin
          st_d.state = HS_SHIFT;
          st_d.shiftLeft = st_q.cfg.shiftCnt;
        end
      end
      HS_SHIFT:
      begin
        target = st_q.cfg.slowSpd;
        if (st_q.shiftLeft <= 0)
        begin
          st_d.state = HS_SLOW;
        end
        else
        begin
          st_d.shiftLeft = st_q.shiftLeft - absVal(useDirect ? dStep : mStep);
        end
      end
      HS_SLOW:
      begin
        target = st_q.cfg.slowSpd;
        if (markSeen && coded && !st_q.haveFirst)
        begin
          st_d.haveFirst = 1'b1;
          st_d.firstMark = st_q.directPos;
        end
        else if (markSeen && coded)
        begin
          // coded pair: second mark judged by spacing
          st_d.markGap = codedGap;
          if (absVal(gap) > $signed(st_q.cfg.markSp))
          begin
            st_d.firstMark = st_q.directPos;
          end
          else
          begin
            st_d.directPos = homePos + (codedGap - $signed(st_q.cfg.closeSp));
            st_d.state = HS_DONE;
          end
        end
        else if (markSeen)
        begin
          if (useDirect)
          begin
            st_d.directPos = homePos;
          end
          else
          begin
            st_d.motorPos = homePos;
          end
          st_d.state = HS_DONE;
        end
      end
      HS_DONE:
      begin
        target = 32'sd0;
        st_d.done = 1'b1;
        st_d.state = HS_IDLE;
      end
      default:
      begin
        st_d.state = HS_IDLE;
      end
    endcase

    if (st_q.cfg.homeSetup[HS_CCW])
    begin
      target = -target;
    end
    // ramp toward the target speed
    if (st_q.speed < target - accelS)
    begin
      st_d.speed = st_q.speed + accelS;
    end
    else if (st_q.speed > target + accelS)
    begin
      st_d.speed = st_q.speed - accelS;
    end
    else
    begin
      st_d.speed = target;
    end

    // register writes
    if (bus.wr)
    begin
      case (widx)
        IDX_DFB_SETUP:  st_d.cfg.dfbSetup = bus.wdata[15:0];
        IDX_HOME_SETUP: st_d.cfg.homeSetup = bus.wdata[15:0];
        IDX_PULSES:     st_d.cfg.pulses = bus.wdata;
        IDX_PERIOD:     st_d.cfg.period = bus.wdata;
        IDX_MOTOR_GEAR: st_d.cfg.motorGear = satGear(bus.wdata);
        IDX_SCREW_GEAR: st_d.cfg.screwGear = satGear(bus.wdata);
        IDX_PITCH:      st_d.cfg.pitch = bus.wdata;
        IDX_FB_GEAR:    st_d.cfg.fbGear = satGear(bus.wdata);
        IDX_LOAD_GEAR:  st_d.cfg.loadGear = satGear(bus.wdata);
        IDX_TRAVEL:     st_d.cfg.travel = bus.wdata;
        IDX_MARK_SP:    st_d.cfg.markSp = bus.wdata;
        IDX_CLOSE_SP:   st_d.cfg.closeSp = bus.wdata;
        IDX_SLOW:       st_d.cfg.slowSpd = bus.wdata;
        IDX_SHIFT:      st_d.cfg.shiftCnt = bus.wdata;
        IDX_FAST:       st_d.cfg.fastSpd = bus.wdata;
        IDX_ACCEL:      st_d.cfg.accel = bus.wdata;
        IDX_HV_MOTOR:   st_d.cfg.hvMotor = bus.wdata;
        IDX_HV_DIRECT:  st_d.cfg.hvDirect = bus.wdata;
        IDX_MO_MOTOR:   st_d.cfg.moMotor = bus.wdata;
        IDX_MO_DIRECT:  st_d.cfg.moDirect = bus.wdata;
        IDX_CTRL:
        begin
          if (bus.wdata[CTRL_ABORT])
          begin
            st_d.state = HS_IDLE;
          end
          else if (bus.wdata[CTRL_START])
          begin
            st_d.state = HS_FAST;
            st_d.done = 1'b0;
            st_d.haveFirst = 1'b0;
          end
        end
        default:
        begin
        end
      endcase
    end

    // register reads, data stand one cycle later
    st_d.rdata = '0;
    if (bus.rd)
    begin
      case (widx)
        IDX_DFB_SETUP:  st_d.rdata = zext16(st_q.cfg.dfbSetup);
        IDX_HOME_SETUP: st_d.rdata = zext16(st_q.cfg.homeSetup);
        IDX_PULSES:     st_d.rdata = st_q.cfg.pulses;
        IDX_PERIOD:     st_d.rdata = st_q.cfg.period;
        IDX_MOTOR_GEAR: st_d.rdata = zext16(st_q.cfg.motorGear);
        IDX_SCREW_GEAR: st_d.rdata = zext16(st_q.cfg.screwGear);
        IDX_PITCH:      st_d.rdata = st_q.cfg.pitch;
        IDX_FB_GEAR:    st_d.rdata = zext16(st_q.cfg.fbGear);
        IDX_LOAD_GEAR:  st_d.rdata = zext16(st_q.cfg.loadGear);
        IDX_TRAVEL:     st_d.rdata = st_q.cfg.travel;
        IDX_MARK_SP:    st_d.rdata = st_q.cfg.markSp;
        IDX_CLOSE_SP:   st_d.rdata = st_q.cfg.closeSp;
        IDX_SLOW:       st_d.rdata = st_q.cfg.slowSpd;
        IDX_SHIFT:      st_d.rdata = st_q.cfg.shiftCnt;
        IDX_FAST:       st_d.rdata = st_q.cfg.fastSpd;
        IDX_ACCEL:      st_d.rdata = st_q.cfg.accel;
        IDX_HV_MOTOR:   st_d.rdata = st_q.cfg.hvMotor;
        IDX_HV_DIRECT:  st_d.rdata = st_q.cfg.hvDirect;
        IDX_MO_MOTOR:   st_d.rdata = st_q.cfg.moMotor;
        IDX_MO_DIRECT:  st_d.rdata = st_q.cfg.moDirect;
        IDX_STATUS:
        begin
          // status word
          st_d.rdata = {22'h000000, travelDiffers,
                        switchActive, st_q.done,
                        st_q.haveFirst, st_q.state, 1'b0};
        end
        IDX_MOTOR_POS:  st_d.rdata = st_q.motorPos;
        IDX_DIRECT_POS: st_d.rdata = st_q.directPos;
        IDX_MARK_GAP:   st_d.rdata = st_q.markGap;
        IDX_RESOLUTION:
        begin
          st_d.rdata = st_q.cfg.dfbSetup[DFB_LINEAR] ? st_q.cfg.period
                                                     : st_q.cfg.pulses;
        end
        IDX_SPEED:      st_d.rdata = st_q.speed;
        default:        st_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q <= '0;
      st_q.state <= HS_IDLE;
      st_q.cfg.dfbSetup <= SETUP_RST[15:0];
      st_q.cfg.homeSetup <= SETUP_RST[15:0];
      st_q.cfg.motorGear <= GEAR_RST;
      st_q.cfg.screwGear <= GEAR_RST;
      st_q.cfg.fbGear <= GEAR_RST;
      st_q.cfg.loadGear <= GEAR_RST;
      st_q.cfg.pitch <= PITCH_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign rdata = st_q.rdata;
  assign speedCmd = st_q.speed;
  assign homeBusy = (st_q.state != HS_IDLE);
  assign homeDone = st_q.done;
endmodule : fsh_home_search

// File: design/fsh_pkg.sv
// shared constants and types for feedback scaling and home search
package fsh_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // word indices; byte address is four times the index
  localparam logic [5:0] IDX_DFB_SETUP  = 6'h00;
  localparam logic [5:0] IDX_HOME_SETUP = 6'h01;
  localparam logic [5:0] IDX_PULSES     = 6'h02;
  localparam logic [5:0] IDX_PERIOD     = 6'h03;
  localparam logic [5:0] IDX_MOTOR_GEAR = 6'h04;
  localparam logic [5:0] IDX_SCREW_GEAR = 6'h05;
  localparam logic [5:0] IDX_PITCH      = 6'h06;
  localparam logic [5:0] IDX_FB_GEAR    = 6'h07;
  localparam logic [5:0] IDX_LOAD_GEAR  = 6'h08;
  localparam logic [5:0] IDX_TRAVEL     = 6'h09;
  localparam logic [5:0] IDX_MARK_SP    = 6'h0A;
  localparam logic [5:0] IDX_CLOSE_SP   = 6'h0B;
  localparam logic [5:0] IDX_SLOW       = 6'h0C;
  localparam logic [5:0] IDX_SHIFT      = 6'h0D;
  localparam logic [5:0] IDX_FAST       = 6'h0E;
  localparam logic [5:0] IDX_ACCEL      = 6'h0F;
  localparam logic [5:0] IDX_HV_MOTOR   = 6'h10;
  localparam logic [5:0] IDX_HV_DIRECT  = 6'h11;
  localparam logic [5:0] IDX_MO_MOTOR   = 6'h12;
  localparam logic [5:0] IDX_MO_DIRECT  = 6'h13;
  localparam logic [5:0] IDX_CTRL       = 6'h14;
  localparam logic [5:0] IDX_STATUS     = 6'h15;
  localparam logic [5:0] IDX_MOTOR_POS  = 6'h16;
  localparam logic [5:0] IDX_DIRECT_POS = 6'h17;
  localparam logic [5:0] IDX_MARK_GAP   = 6'h18;
  localparam logic [5:0] IDX_RESOLUTION = 6'h19;
  localparam logic [5:0] IDX_SPEED      = 6'h1A;
  // direct feedback setup fields
  localparam int DFB_LINEAR = 0;
  localparam int DFB_CODED  = 1;
  localparam int DFB_INVERT = 3;
  localparam int DFB_STRUCT = 5;
  // home search setup fields
  localparam int HS_CCW    = 0;
  localparam int HS_NC     = 1;
  localparam int HS_DIRECT = 3;
  localparam int HS_NOSW   = 5;
  // control fields
  localparam int CTRL_START = 0;
  localparam int CTRL_ABORT = 1;
  // gear limit and reset values
  localparam logic [15:0] GEAR_MAX    = 16'h7FFF;
  localparam logic [15:0] GEAR_RST    = 16'h0001;
  localparam logic [31:0] PITCH_RST   = 32'h0000_0000;
  localparam logic [31:0] SETUP_RST   = 32'h0000_0000;

  typedef enum logic [4:0] {
    HS_IDLE  = 5'b00001,
    HS_FAST  = 5'b00010,
    HS_SHIFT = 5'b00100,
    HS_SLOW  = 5'b01000,
    HS_DONE  = 5'b10000
  } fsh_state_t;

  typedef struct packed {
    logic a;
    logic b;
    logic mark;
  } fsh_enc_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } fsh_bus_t;

  typedef struct packed {
    logic [15:0] dfbSetup;
    logic [15:0] homeSetup;
    logic [31:0] pulses;
    logic [31:0] period;
    logic [15:0] motorGear;
    logic [15:0] screwGear;
    logic [31:0] pitch;
    logic [15:0] fbGear;
    logic [15:0] loadGear;
    logic [31:0] travel;
    logic [31:0] markSp;
    logic [31:0] closeSp;
    logic [31:0] slowSpd;
    logic [31:0] shiftCnt;
    logic [31:0] fastSpd;
    logic [31:0] accel;
    logic [31:0] hvMotor;
    logic [31:0] hvDirect;
    logic [31:0] moMotor;
    logic [31:0] moDirect;
  } fsh_cfg_t;
endpackage : fsh_pkg

// File: sim/fsh_home_search_properties.sv
// assertion checker for the feedback scaling and home search block
`timescale 1ns/1ps
module fsh_props (
  input logic                        clk_sys,
  input logic                        resetn,
  input fsh_pkg::fsh_bus_t           bus,
  input logic [fsh_pkg::DATA_W-1:0]  rdata,
  input fsh_pkg::fsh_enc_t           motorEnc,
  input fsh_pkg::fsh_enc_t           directEnc,
  input logic                        homeSwitch,
  input logic signed [31:0]          speedCmd,
  input logic                        homeBusy,
  input logic                        homeDone
);
  import fsh_pkg::*;
  logic        [15:0] hsQ;
  logic signed [31:0] accQ;
  wire         [5:0]  idx = bus.addr[7:2];
  wire                ctrlWr = bus.wr && idx == IDX_CTRL;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // shadow of home setup and acceleration
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      hsQ  <= '0;
      accQ <= '0;
    end
    else if (bus.wr)
    begin
      if (idx == IDX_HOME_SETUP)
        hsQ <= bus.wdata[15:0];
      if (idx == IDX_ACCEL)
        accQ <= bus.wdata;
    end
  property p_gearMotor;
    bus.rd && (idx == IDX_MOTOR_GEAR || idx == IDX_SCREW_GEAR) |=> rdata <= {16'h0, GEAR_MAX};
  endproperty
  a_gearMotor: assert property (p_gearMotor) else $error("motor gear above limit");
  property p_gearFb;
    bus.rd && (idx == IDX_FB_GEAR || idx == IDX_LOAD_GEAR) |=> rdata <= {16'h0, GEAR_MAX};
  endproperty
  a_gearFb: assert property (p_gearFb) else $error("feedback gear above limit");
  property p_dirCw;
    homeBusy && !hsQ[HS_CCW] |-> !speedCmd[31];
  endproperty
  a_dirCw: assert property (p_dirCw) else $error("clockwise search ran negative");
  property p_dirCcw;
    homeBusy && hsQ[HS_CCW] |-> speedCmd <= 0;
  endproperty
  a_dirCcw: assert property (p_dirCcw) else $error("ccw search ran positive");
  property p_ramp;
    1'b1 |=> (speedCmd - $past(speedCmd) <= accQ) && ($past(speedCmd) - speedCmd <= accQ);
  endproperty
  a_ramp: assert property (p_ramp) else $error("speed step above acceleration");
  property p_noMove;
    !homeBusy && !bus.wr && speedCmd >= 0 |=> speedCmd >= 0 && speedCmd <= $past(speedCmd);
  endproperty
  a_noMove: assert property (p_noMove) else $error("speed grew while idle");
  property p_start;
    ctrlWr && bus.wdata[CTRL_START] && !bus.wdata[CTRL_ABORT] |=> homeBusy && !homeDone;
  endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_doneEdge;
    $rose(homeDone) |-> ##[0:2] !homeBusy;
  endproperty
  a_doneEdge: assert property (p_doneEdge) else $error("done while still busy");
  c_done: cover property ($rose(homeDone));
  c_abort: cover property (ctrlWr && bus.wdata[CTRL_ABORT]);
  c_ccw: cover property (homeBusy && hsQ[HS_CCW]);
endmodule : fsh_props

bind fsh_home_search fsh_props i_fsh_props (.clk_sys(clk_sys), .resetn(resetn), .bus(bus),
  .rdata(rdata), .motorEnc(motorEnc), .directEnc(directEnc), .homeSwitch(homeSwitch),
  .speedCmd(speedCmd), .homeBusy(homeBusy), .homeDone(homeDone));

// File: sim/fsh_enc_model.sv
// quadrature encoder and home switch model
`timescale 1ns/1ps
module fsh_enc_model #(
  parameter int SW_POS = 10
) (
  input  logic               clk_sys,
  input  logic               resetn,
  input  logic signed [31:0] speedCmd,
  input  logic               swNc,
  output fsh_pkg::fsh_enc_t  motorEnc,
  output fsh_pkg::fsh_enc_t  directEnc,
  output logic               homeSwitch
);
  import fsh_pkg::*;
  logic signed [31:0] sub;
  logic signed [31:0] cnt;
  logic        [1:0]  ph;
  assign cnt = sub >>> 3;
  assign ph  = cnt[1:0];
  // one count per eight cycles of motion
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
      sub <= '0;
    else if (speedCmd != 0)
      sub <= speedCmd[31] ? sub - 1 : sub + 1;
  assign motorEnc   = '{a: ph[1], b: ph[1] ^ ph[0], mark: cnt[3:0] == 4'h0};
  assign directEnc  = motorEnc;
  assign homeSwitch = ((cnt >= SW_POS) || (cnt <= -SW_POS)) ^ swNc;
endmodule : fsh_enc_model

// File: sim/tb_top.sv
// self-checking bench for the feedback scaling and home search block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samplesChecked++; if ((g) !== (e)) begin nErrors++; \
  $display("wrong value %s expected %0h seen %0h", nm, (e), (g)); end end
module tb_top;
  import fsh_pkg::*;
  logic               clk_sys = 1'b0;
  logic               resetn = 1'b0;
  fsh_bus_t           bus = '0;
  logic               swNc = 1'b0;
  logic [DATA_W-1:0]  rdata;
  fsh_enc_t           motorEnc;
  fsh_enc_t           directEnc;
  logic               homeSwitch;
  logic               homeBusy;
  logic               homeDone;
  logic signed [31:0] speedCmd;
  logic signed [31:0] pkMax;
  logic signed [31:0] pkMin;
  int                 nErrors = 0;
  int                 samplesChecked = 0;

  always #2.5 clk_sys = ~clk_sys;

  fsh_home_search i_fsh_home_search (.clk_sys(clk_sys), .resetn(resetn), .bus(bus),
    .rdata(rdata), .motorEnc(motorEnc), .directEnc(directEnc), .homeSwitch(homeSwitch),
    .speedCmd(speedCmd), .homeBusy(homeBusy), .homeDone(homeDone));
  fsh_enc_model i_fsh_enc_model (.clk_sys(clk_sys), .resetn(resetn), .speedCmd(speedCmd),
    .swNc(swNc), .motorEnc(motorEnc), .directEnc(directEnc), .homeSwitch(homeSwitch));

  task automatic summarize;
    if (nErrors == 0 && samplesChecked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic doReset;
    resetn <= 1'b0;
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
  endtask : doReset

  task automatic regWr(input logic [5:0] idx, input logic [31:0] d);
    @(posedge clk_sys);
    bus <= '{addr: {idx, 2'b00}, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask : regWr

  task automatic regRd(input logic [5:0] idx, output logic [31:0] d);
    @(posedge clk_sys);
    bus <= '{addr: {idx, 2'b00}, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    @(negedge clk_sys);
    d = rdata;
  endtask : regRd

  task automatic chkRd(input string nm, input logic [5:0] idx, input logic [31:0] e);
    logic [31:0] d;
    regRd(idx, d);
    `CHK(nm, e, d)
  endtask : chkRd

  task automatic waitDone;
    int n;
    n = 0;
    pkMax = 0;
    pkMin = 0;
    while (homeDone !== 1'b1 && n < 4000)
    begin
      @(negedge clk_sys);
      n++;
      if (speedCmd > pkMax)
        pkMax = speedCmd;
      if (speedCmd < pkMin)
        pkMin = speedCmd;
    end
    `CHK("homing finished", 1'b1, homeDone)
  endtask : waitDone

  task automatic scenRegs;
    logic [5:0]  gi [4] = '{IDX_MOTOR_GEAR, IDX_SCREW_GEAR, IDX_FB_GEAR, IDX_LOAD_GEAR};
    logic [31:0] gw [4] = '{32'h0000_8000, 32'h0000_7FFF, 32'h0001_0000, 32'h0000_0005};
    logic [31:0] ge [4] = '{32'h0000_7FFF, 32'h0000_7FFF, 32'h0000_7FFF, 32'h0000_0005};
    logic [31:0] d;
    doReset;
    for (int i = 0; i < 4; i++)
    begin
      chkRd("gear reset", gi[i], {16'h0, GEAR_RST});
      regWr(gi[i], gw[i]);
      chkRd("gear value", gi[i], ge[i]);
    end
    chkRd("pitch reset", IDX_PITCH, PITCH_RST);
    regWr(IDX_PITCH, 32'h0005_7E40);
    chkRd("pitch", IDX_PITCH, 32'h0005_7E40);
    regWr(IDX_DFB_SETUP, 32'hFFFF_0001);
    chkRd("setup width", IDX_DFB_SETUP, 32'h0000_0001);
    regWr(IDX_PULSES, 32'h0000_0064);
    regWr(IDX_PERIOD, 32'h0000_0014);
    regWr(IDX_TRAVEL, 32'h0000_0003);
    chkRd("linear resolution", IDX_RESOLUTION, 32'h0000_0014);
    regRd(IDX_STATUS, d);
    `CHK("travel flag linear", 1'b0, d[9])
    regWr(IDX_DFB_SETUP, 32'h0000_0000);
    chkRd("rotary resolution", IDX_RESOLUTION, 32'h0000_0064);
    regRd(IDX_STATUS, d);
    `CHK("travel flag rotary", 1'b1, d[9])
    chkRd("unmapped", 6'h3F, 32'h0);
    chkRd("control", IDX_CTRL, 32'h0);
  endtask : scenRegs

  task automatic scenSkip;
    doReset;
    regWr(IDX_DFB_SETUP, 32'h0000_0008);
    regWr(IDX_HOME_SETUP, 32'h0000_0020);
    regWr(IDX_SLOW, 32'h0000_0003);
    regWr(IDX_FAST, 32'h0000_0009);
    regWr(IDX_ACCEL, 32'h0000_0003);
    regWr(IDX_HV_MOTOR, 32'h0000_0100);
    regWr(IDX_MO_MOTOR, 32'h0000_0020);
    regWr(IDX_CTRL, 32'h0000_0001);
    repeat (6) @(posedge clk_sys);
    regWr(IDX_CTRL, 32'h0000_0003);
    @(negedge clk_sys);
    `CHK("busy after abort", 1'b0, homeBusy)
    regWr(IDX_CTRL, 32'h0000_0001);
    waitDone;
    `CHK("peak speed", 32'sd3, pkMax)
    `CHK("lowest speed", 32'sd0, pkMin)
    chkRd("motor pos", IDX_MOTOR_POS, 32'h0000_0120);
    chkRd("inverted direct pos", IDX_DIRECT_POS, 32'hFFFF_FFF0);
    repeat (20) @(posedge clk_sys);
    chkRd("motor pos held", IDX_MOTOR_POS, 32'h0000_0120);
  endtask : scenSkip

  task automatic scenSwitch;
    doReset;
    swNc <= 1'b1;
    regWr(IDX_HOME_SETUP, 32'h0000_000B);
    regWr(IDX_SLOW, 32'h0000_0002);
    regWr(IDX_FAST, 32'h0000_0007);
    regWr(IDX_ACCEL, 32'h0000_0007);
    regWr(IDX_SHIFT, 32'h0000_0008);
    regWr(IDX_HV_MOTOR, 32'h0000_0999);
    regWr(IDX_HV_DIRECT, 32'h0000_0040);
    regWr(IDX_MO_DIRECT, 32'h0000_0005);
    regWr(IDX_CTRL, 32'h0000_0001);
    waitDone;
    `CHK("ccw peak", -32'sd7, pkMin)
    `CHK("ccw highest", 32'sd0, pkMax)
    chkRd("direct pos", IDX_DIRECT_POS, 32'h0000_0045);
    chkRd("motor count", IDX_MOTOR_POS, 32'hFFFF_FFE0);
  endtask : scenSwitch

  task automatic scenCoded;
    logic [31:0] d;
    doReset;
    regWr(IDX_DFB_SETUP, 32'h0000_0022);
    regWr(IDX_HOME_SETUP, 32'h0000_0028);
    regWr(IDX_SLOW, 32'h0000_0001);
    regWr(IDX_FAST, 32'h0000_0001);
    regWr(IDX_ACCEL, 32'h0000_0001);
    regWr(IDX_MARK_SP, 32'h0000_0020);
    regWr(IDX_CLOSE_SP, 32'h0000_0004);
    regWr(IDX_HV_DIRECT, 32'h0000_0100);
    regWr(IDX_CTRL, 32'h0000_0001);
    waitDone;
    chkRd("coded gap", IDX_MARK_GAP, 32'hFFFF_FFF0);
    chkRd("coded pos", IDX_DIRECT_POS, 32'h0000_00EC);
    regRd(IDX_STATUS, d);
    `CHK("first mark flag", 1'b1, d[6])
  endtask : scenCoded

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    nErrors++;
    summarize;
  end

  initial
  begin
    scenRegs;
    scenSkip;
    scenSwitch;
    scenCoded;
    summarize;
  end
endmodule : tb_top
